// ---- hw/hsr_map.svh ----
`ifndef HSR_MAP_SVH
`define HSR_MAP_SVH

// Measured value and limit width
`define HSR_VAL_W 32
// Number of grade outputs in binning
`define HSR_NUM_GRADES 8
// Largest scan batch
`define HSR_MAX_CH 100
// Channel counter width
`define HSR_CH_W 7
// Scan pause counter width, in clk cycles
`define HSR_DLY_W 24
// Number of custom logic outputs
`define HSR_NUM_CUSTOM 2
// Condition mask width for custom outputs
`define HSR_COND_W 4

`endif

// ---- hw/hsr_pkg.sv ----
package hsr_pkg;
`include "hsr_map.svh"

    // Active function of the shared port
    typedef enum logic [1:0] {HSR_COMPARE, HSR_BINNING, HSR_SCAN} hsr_mode_t;

    // One limit judgment, exactly one bit set
    typedef struct packed {
        logic pass;
        logic hi;
        logic lo;
    } hsr_judge_t;

    // Result pins carried across to the link domain
    typedef struct packed {
        logic passResult;
        logic failResult;
        logic aboveLimit;
        logic belowLimit;
        logic [`HSR_NUM_GRADES-1:0] grade;
        logic outOfAllBins;
        logic customLogicOutOne;
        logic customLogicOutTwo;
        logic relayControl;
        logic scanPass;
        logic scanLow;
        logic scanHigh;
    } hsr_res_t;

    // Word handed from core to link
    typedef struct packed {
        hsr_res_t res;
        logic group;
        logic last;
    } hsr_xfer_t;

    // Everything the port drives
    typedef struct packed {
        hsr_res_t res;
        logic conversionDone;
        logic ready;
        logic groupClock;
        logic batchDoneStrobe;
    } hsr_pins_t;

    // Configuration from the instrument's setup logic
    typedef struct packed {
        hsr_mode_t mode;
        logic extTrigMode;
        logic trigFallEdge;
        logic [`HSR_VAL_W-1:0] lowLimit;
        logic [`HSR_VAL_W-1:0] highLimit;
        logic [`HSR_NUM_GRADES-1:0] binEnable;
        logic [`HSR_NUM_GRADES-1:0][`HSR_VAL_W-1:0] binLow;
        logic [`HSR_NUM_GRADES-1:0][`HSR_VAL_W-1:0] binHigh;
        logic [`HSR_NUM_CUSTOM-1:0][`HSR_COND_W-1:0] customSel;
        logic [`HSR_NUM_CUSTOM-1:0] customLevel;
        logic [`HSR_CH_W-1:0] chanCount;
        logic [`HSR_DLY_W-1:0] scanDelay;
    } hsr_cfg_t;

    // Limit judgment, shared by compare and scan
    function automatic hsr_judge_t hsr_judge_f(input logic [`HSR_VAL_W-1:0] val,
                                               input logic [`HSR_VAL_W-1:0] lowLim,
                                               input logic [`HSR_VAL_W-1:0] highLim);
        hsr_judge_t j;
        j.lo = val < lowLim;
        j.hi = (val > highLim) && !(val < lowLim);
        j.pass = !j.lo && !j.hi;
        return j;
    endfunction

endpackage

// ---- hw/hsr_pin_sync.sv ----
`timescale 1ns/1ps
module hsr_pin_sync import hsr_pkg::*; #(
    parameter int W = 1
) (
    // Clock and reset of the receiving domain
    input wire logic clk,
    input wire logic reset,
    // Asynchronous levels in, synchronised levels out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    generate
        if (W < 1) begin : gBadW
            $error("hsr_pin_sync: W must be at least 1");
        end
    endgenerate

    // Two stages; the first is seen only by the second
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule // hsr_pin_sync

// ---- hw/hsr_handler_scan.sv ----
// Contract
// RL1 - Pin set follows the active function: handler set or scan set.
// RL2 - One trigger starts exactly one measurement, in every mode; in scan mode the code starts one per channel of the batch.
// RL3 - Compare: fail high when judgment is HI or LO.
// RL4 - Compare: above_limit high on HI, below_limit high on LO.
// RL5 - Compare: pass_result high when judgment is IN.
// RL6 - External trigger: conversion_done high once conversion completes.
// RL7 - External trigger: ready high when measurement finished, next trigger accepted.
// RL8 - Binning: the one grade output whose range holds the result goes high.
// RL9 - Binning: out_of_all_bins high when no grade range holds the result.
// RL10 - Compare and binning: custom outputs take configured level when condition met.
// RL11 - Scan pins active only in scan mode, batches up to 100.
// RL12 - Scan: relay_control switches the external relay for each channel.
// RL13 - Scan: pass, LO, HI outputs show the current channel's judgment.
// RL14 - Scan: one group_clock pulse per valid output group, up to 100.
// RL15 - Scan: one batch_done_strobe pulse after all groups presented.
// RL16 - Scan assignment replaces handler assignment while scanning.
// RL17 - Trigger edge, rising or falling, chosen by configuration.
// RL18 - Scan: configurable pause between successive channel measurements.
// RL19 - LO below lower limit, HI above upper limit, IN otherwise.
// RL20 - Judgment outputs hold until next result; inactive mode outputs low.
// RL21 - At most one grade or out-of-bins; exactly one of pass, HI, LO.
`timescale 1ns/1ps
`include "hsr_map.svh"
module hsr_handler_scan import hsr_pkg::*; #(
    parameter int MAX_CH = `HSR_MAX_CH
) (
    // Core clock, enable and reset
    input wire logic clk,
    input wire logic ce,
    input wire logic reset,
    // Port clock
    input wire logic linkClk,
    // Trigger pin, asynchronous
    input wire logic trigPin,
    // Configuration
    input wire hsr_cfg_t cfg,
    // Measurement engine
    output logic measStart,
    input wire logic adcDone,
    input wire logic measDone,
    input wire logic [`HSR_VAL_W-1:0] measValue,
    // Status
    output logic busy,
    // Port outputs, linkClk domain
    output hsr_pins_t pins
);

    typedef enum logic [2:0] {ST_IDLE, ST_MEAS, ST_SEND, ST_PAUSE, ST_FLUSH} hsr_state_t;

    generate
        if (MAX_CH < 1 || MAX_CH > (1 << `HSR_CH_W) - 1) begin : gBadMax
            $error("hsr_handler_scan: MAX_CH out of range for channel counter");
        end
    endgenerate

    // ---------------- Core domain ----------------
    hsr_state_t state_r, state_nxt;
    hsr_xfer_t word_r, word_nxt;
    hsr_mode_t modePrev_r;
    logic reqTgl_r, reqTgl_nxt;
    logic trigPrev_r;
    logic convDone_r, convDone_nxt;
    logic ready_r, ready_nxt;
    logic measStart_r, measStart_nxt;
    logic [`HSR_CH_W-1:0] chan_r, chan_nxt;
    logic [`HSR_DLY_W-1:0] dly_r, dly_nxt;
    logic trigS;
    logic ackS;
    logic ackTgl_r;

    // Trigger pin into the core domain
    hsr_pin_sync #(.W(1)) uTrigSync (
        .clk(clk),
        .reset(reset),
        .d(trigPin),
        .q(trigS)
    );

    // Acknowledge toggle back from the link domain
    hsr_pin_sync #(.W(1)) uAckSync (
        .clk(clk),
        .reset(reset),
        .d(ackTgl_r),
        .q(ackS)
    );

    // Edge select on the synchronised trigger
    wire logic trigRise = trigS & ~trigPrev_r;
    wire logic trigFall = ~trigS & trigPrev_r;
    wire logic trigHit = cfg.trigFallEdge ? trigFall : trigRise; // RL17

    // A handover is outstanding until the ack toggle matches
    wire logic xferBusy = reqTgl_r ^ ackS;
    wire logic isScan = cfg.mode == HSR_SCAN;
    wire logic modeChanged = cfg.mode != modePrev_r;

    // Batch length clipped to 1..MAX_CH
    wire logic [`HSR_CH_W-1:0] maxCh = `HSR_CH_W'(MAX_CH);
    wire logic [`HSR_CH_W-1:0] chanLimit = (cfg.chanCount == '0) ? `HSR_CH_W'(1) :
        (cfg.chanCount > maxCh) ? maxCh : cfg.chanCount; // RL11
    wire logic lastChan = (chan_r + `HSR_CH_W'(1)) >= chanLimit;

    // Limit judgment of the fresh value
    wire hsr_judge_t judge = hsr_judge_f(measValue, cfg.lowLimit, cfg.highLimit); // RL19

    // Grade ranges, one comparator pair each
    logic [`HSR_NUM_GRADES-1:0] inGrade;
    genvar gi;
    generate
        for (gi = 0; gi < `HSR_NUM_GRADES; gi++) begin : gGrade
            assign inGrade[gi] = cfg.binEnable[gi] &&
                measValue >= cfg.binLow[gi] && measValue <= cfg.binHigh[gi]; // RL8
        end
    endgenerate

    // Overlapping ranges resolve to the lowest grade, keeping it one-hot
    wire logic [`HSR_NUM_GRADES-1:0] gradeOne = inGrade & ~(inGrade - `HSR_NUM_GRADES'(1)); // RL21
    wire logic outOfBins = ~|inGrade; // RL9

    // Custom outputs: mask over {pass, hi, lo, out of bins}
    wire logic inCompare = cfg.mode == HSR_COMPARE;
    wire logic [`HSR_COND_W-1:0] condFlags = {judge.pass & inCompare, judge.hi & inCompare,
        judge.lo & inCompare, outOfBins & ~inCompare};
    logic [`HSR_NUM_CUSTOM-1:0] customOut;
    generate
        for (gi = 0; gi < `HSR_NUM_CUSTOM; gi++) begin : gCustom
            assign customOut[gi] = (|(cfg.customSel[gi] & condFlags)) ?
                cfg.customLevel[gi] : ~cfg.customLevel[gi]; // RL10
        end
    endgenerate

    // Result word for the active function; other fields stay low
    hsr_res_t resNew;
    always_comb begin
        resNew = '0;
        unique case (cfg.mode)
            HSR_COMPARE: begin
                resNew.passResult = judge.pass; // RL5
                resNew.failResult = judge.hi | judge.lo; // RL3
                resNew.aboveLimit = judge.hi; // RL4
                resNew.belowLimit = judge.lo; // RL4
                resNew.customLogicOutOne = customOut[0]; // RL10
                resNew.customLogicOutTwo = customOut[1];
            end
            HSR_BINNING: begin
                resNew.grade = gradeOne; // RL8
                resNew.outOfAllBins = outOfBins; // RL9
                resNew.customLogicOutOne = customOut[0]; // RL10
                resNew.customLogicOutTwo = customOut[1];
            end
            HSR_SCAN: begin
                resNew.relayControl = ~lastChan; // RL12
                resNew.scanPass = judge.pass; // RL13
                resNew.scanLow = judge.lo;
                resNew.scanHigh = judge.hi;
            end
            default: begin
                resNew = '0; // RL1
            end
        endcase
    end

    // Sequencer: trigger, measure, hand over, pause between channels
    always_comb begin
        state_nxt = state_r;
        word_nxt = word_r;
        reqTgl_nxt = reqTgl_r;
        convDone_nxt = convDone_r;
        ready_nxt = ready_r;
        measStart_nxt = 1'b0;
        chan_nxt = chan_r;
        dly_nxt = dly_r;
        unique case (state_r)
            ST_IDLE: begin
                if (!xferBusy && modeChanged) begin
                    word_nxt = '0; // RL20
                    reqTgl_nxt = ~reqTgl_r;
                    convDone_nxt = 1'b0;
                    state_nxt = ST_FLUSH;
                end else if (!xferBusy && trigHit) begin
                    measStart_nxt = 1'b1; // RL2
                    chan_nxt = '0;
                    convDone_nxt = 1'b0;
                    ready_nxt = 1'b0;
                    state_nxt = ST_MEAS;
                end
            end
            ST_MEAS: begin
                if (adcDone || measDone) begin
                    convDone_nxt = 1'b1; // RL6
                end
                if (measDone) begin
                    word_nxt.res = resNew;
                    word_nxt.group = isScan; // RL14
                    word_nxt.last = isScan & lastChan; // RL15
                    reqTgl_nxt = ~reqTgl_r;
                    state_nxt = ST_SEND;
                end
            end
            ST_SEND: begin
                if (!xferBusy) begin
                    if (isScan && !lastChan) begin
                        chan_nxt = chan_r + `HSR_CH_W'(1);
                        dly_nxt = '0;
                        state_nxt = ST_PAUSE;
                    end else begin
                        ready_nxt = 1'b1; // RL7
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_PAUSE: begin
                if (dly_r >= cfg.scanDelay) begin
                    measStart_nxt = 1'b1; // RL18
                    state_nxt = ST_MEAS;
                end else begin
                    dly_nxt = dly_r + `HSR_DLY_W'(1);
                end
            end
            ST_FLUSH: begin
                if (!xferBusy) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Core state, frozen while ce is low
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= ST_IDLE;
            word_r <= '0;
            reqTgl_r <= 1'b0;
            trigPrev_r <= 1'b0;
            convDone_r <= 1'b0;
            ready_r <= 1'b1;
            measStart_r <= 1'b0;
            chan_r <= '0;
            dly_r <= '0;
            modePrev_r <= HSR_COMPARE;
        end else if (ce) begin
            state_r <= state_nxt;
            word_r <= word_nxt;
            reqTgl_r <= reqTgl_nxt;
            trigPrev_r <= trigS;
            convDone_r <= convDone_nxt;
            ready_r <= ready_nxt;
            measStart_r <= measStart_nxt;
            chan_r <= chan_nxt;
            dly_r <= dly_nxt;
            if (state_r == ST_IDLE && !xferBusy) begin
                modePrev_r <= cfg.mode;
            end
        end
    end

    // Handler status levels; scan owns the port otherwise
    wire logic extHandler = cfg.extTrigMode & ~isScan; // RL16
    wire logic convLvl = extHandler & convDone_r; // RL6
    wire logic readyLvl = extHandler & ready_r & (state_r == ST_IDLE); // RL7

    // Held in flops so the link sees glitch-free levels
    logic convLvl_r;
    logic readyLvl_r;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            convLvl_r <= 1'b0;
            readyLvl_r <= 1'b0;
        end else if (ce) begin
            convLvl_r <= convLvl;
            readyLvl_r <= readyLvl;
        end
    end

    assign measStart = measStart_r;
    assign busy = state_r != ST_IDLE;

    // ---------------- Link domain ----------------
    logic reqS;
    logic [1:0] lvlS;
    logic reqPrev_r;
    hsr_res_t res_r;
    logic groupClk_r;
    logic strobePend_r;
    logic strobe_r;

    // Request toggle and status levels into the link domain
    hsr_pin_sync #(.W(1)) uReqSync (
        .clk(linkClk),
        .reset(reset),
        .d(reqTgl_r),
        .q(reqS)
    );

    hsr_pin_sync #(.W(2)) uLvlSync (
        .clk(linkClk),
        .reset(reset),
        .d({convLvl_r, readyLvl_r}),
        .q(lvlS)
    );

    // word_r is held still until the ack returns, so a direct capture is safe
    wire logic newWord = reqS ^ reqPrev_r;

    // Capture results, pulse group clock, then the batch strobe
    always_ff @(posedge linkClk or posedge reset) begin
        if (reset) begin
            reqPrev_r <= 1'b0;
            ackTgl_r <= 1'b0;
            res_r <= '0;
            groupClk_r <= 1'b0;
            strobePend_r <= 1'b0;
            strobe_r <= 1'b0;
        end else begin
            reqPrev_r <= reqS;
            ackTgl_r <= reqS;
            if (newWord) begin
                res_r <= word_r.res; // RL20
            end
            groupClk_r <= newWord & word_r.group; // RL14
            strobePend_r <= newWord & word_r.last;
            strobe_r <= strobePend_r; // RL15
        end
    end

    // Port drive
    assign pins.res = res_r; // RL1
    assign pins.conversionDone = lvlS[1];
    assign pins.ready = lvlS[0];
    assign pins.groupClock = groupClk_r;
    assign pins.batchDoneStrobe = strobe_r;

endmodule // hsr_handler_scan

// ---- tb/hsr_handler_scan_checker.sv ----
`timescale 1ns/1ps
`include "hsr_map.svh"
module hsr_handler_scan_checker import hsr_pkg::*; #(
    parameter int MAX_CH = 100
) (
    // Clocks and reset
    input wire logic clk,
    input wire logic linkClk,
    input wire logic reset,
    // Block inputs
    input wire logic ce,
    input wire logic trigPin,
    input wire hsr_cfg_t cfg,
    input wire logic adcDone,
    input wire logic measDone,
    input wire logic [`HSR_VAL_W-1:0] measValue,
    // Block outputs
    input wire logic measStart,
    input wire logic busy,
    input wire hsr_pins_t pins
);
    // Groups since last strobe, to bound the batch
    logic [7:0] grpCnt_r;
    always_ff @(posedge linkClk or posedge reset) begin
        if (reset) grpCnt_r <= 8'h00;
        else if (pins.batchDoneStrobe) grpCnt_r <= 8'h00;
        else if (pins.groupClock) grpCnt_r <= grpCnt_r + 8'h01;
    end

    start_pulse_a:
        assert property (@(posedge clk) disable iff (reset)
            measStart |-> busy ##1 (!measStart && busy)) else $error("bad start pulse");
    ready_idle_a:
        assert property (@(posedge clk) disable iff (reset)
            $rose(pins.ready) |-> !busy) else $error("ready while busy");
    conv_ext_a:
        assert property (@(posedge clk) disable iff (reset) $rose(pins.conversionDone)
            |-> cfg.extTrigMode && cfg.mode != HSR_SCAN) else $error("stray conv done");
    fail_sum_a:
        assert property (@(posedge linkClk) disable iff (reset) pins.res.failResult ==
            (pins.res.aboveLimit || pins.res.belowLimit)) else $error("fail mismatch");
    judge_one_a:
        assert property (@(posedge linkClk) disable iff (reset) $onehot0({pins.res.passResult,
            pins.res.aboveLimit, pins.res.belowLimit})) else $error("two judgments");
    grade_one_a:
        assert property (@(posedge linkClk) disable iff (reset)
            $onehot0({pins.res.grade, pins.res.outOfAllBins})) else $error("two grades");
    group_pulse_a:
        assert property (@(posedge linkClk) disable iff (reset) pins.groupClock |->
            $onehot({pins.res.scanPass, pins.res.scanLow, pins.res.scanHigh})
            ##1 !pins.groupClock) else $error("bad group");
    strobe_last_a:
        assert property (@(posedge linkClk) disable iff (reset) pins.batchDoneStrobe |->
            $past(pins.groupClock) && !pins.res.relayControl ##1 !pins.batchDoneStrobe)
        else $error("bad strobe");
    scan_only_a:
        assert property (@(posedge linkClk) disable iff (reset) pins.groupClock |->
            !pins.res.passResult && !pins.res.failResult && pins.res.grade == 8'h00
            && !pins.ready) else $error("handler pin in scan");
    batch_max_a:
        assert property (@(posedge linkClk) disable iff (reset)
            {24'h0, grpCnt_r} <= MAX_CH) else $error("too many groups");

    // Main scenarios reached
    cover property (@(posedge linkClk) pins.batchDoneStrobe);
    cover property (@(posedge linkClk) pins.res.outOfAllBins);
    cover property (@(posedge clk) measStart && cfg.mode == HSR_BINNING);
endmodule // hsr_handler_scan_checker

bind hsr_handler_scan hsr_handler_scan_checker #(.MAX_CH(MAX_CH)) chk_i (
    .clk(clk), .linkClk(linkClk), .reset(reset), .ce(ce), .trigPin(trigPin), .cfg(cfg),
    .adcDone(adcDone), .measDone(measDone), .measValue(measValue),
    .measStart(measStart), .busy(busy), .pins(pins));

// ---- tb/hsr_meas_model.sv ----
`timescale 1ns/1ps
`include "hsr_map.svh"
module hsr_meas_model (
    // Clock and start request
    input wire logic clk,
    input wire logic measStart,
    // Answer lag and value, set by the bench
    input wire logic [7:0] lagCycles,
    input wire logic [`HSR_VAL_W-1:0] val,
    // Answers
    output logic adcDone,
    output logic measDone,
    output logic [`HSR_VAL_W-1:0] measValue
);
    // One conversion and one result per start, after a set lag
    initial begin
        adcDone = 1'b0;
        measDone = 1'b0;
        measValue = '0;
        forever begin
            @(negedge clk);
            if (measStart === 1'b1) begin
                repeat (lagCycles) @(negedge clk);
                adcDone = 1'b1;
                @(negedge clk);
                adcDone = 1'b0;
                repeat (2) @(negedge clk);
                measValue = val;
                measDone = 1'b1;
                @(negedge clk);
                measDone = 1'b0;
                measValue = ~val; // Stale value must not look valid
            end
        end
    end
endmodule // hsr_meas_model

// ---- tb/tb_hsr_handler_scan.sv ----
`timescale 1ns/1ps
module tb_hsr_handler_scan import hsr_pkg::*;;
    // Clocks, reset and block pins
    logic clk = 1'b0;
    logic linkClk = 1'b0;
    logic reset, ce, trigPin, measStart, adcDone, measDone, busy;
    logic [31:0] measValue, curVal, modelVal;
    logic [7:0] lag;
    hsr_cfg_t cfg;
    hsr_pins_t pins;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0, doneCyc = 0, mcnt = 0, strbCnt = 0, minGap = 0;
    hsr_res_t grpQ[$];
    localparam logic [31:0] SCANV [3] = '{32'hfa, 32'h32, 32'h96};

    // Core clock, and a link clock whose period is unrelated to it
    always #2.5 clk = ~clk;
    always #32 linkClk = ~linkClk;

    hsr_handler_scan #(.MAX_CH(4)) DUT (
        .clk(clk), .ce(ce), .reset(reset), .linkClk(linkClk), .trigPin(trigPin), .cfg(cfg),
        .measStart(measStart), .adcDone(adcDone), .measDone(measDone),
        .measValue(measValue), .busy(busy), .pins(pins));
    hsr_meas_model engine (.clk(clk), .measStart(measStart), .lagCycles(lag), .val(modelVal),
        .adcDone(adcDone), .measDone(measDone), .measValue(measValue));
    // Scan channels cycle LO, IN, HI
    assign modelVal = (cfg.mode == HSR_SCAN) ? SCANV[mcnt % 3] : curVal;

    // Count starts, pauses, groups and strobes
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (measDone) doneCyc <= cyc;
        if (measStart) mcnt <= mcnt + 1;
        // First start of a batch follows idle time, not a channel pause
        if (measStart && mcnt > 0 && cyc - doneCyc < minGap) minGap <= cyc - doneCyc;
    end
    always @(posedge linkClk) begin
        if (pins.groupClock === 1'b1) grpQ.push_back(pins.res);
        if (pins.batchDoneStrobe === 1'b1) strbCnt <= strbCnt + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic pulse();
        @(negedge clk);
        trigPin = 1'b1;
        repeat (6) @(negedge clk);
        trigPin = 1'b0;
        repeat (6) @(negedge clk);
    endtask

    // Bounded wait for idle, then let the result cross to the port
    task automatic wait_idle();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 5000) begin
            @(negedge clk);
            k++;
        end
        chk(k < 5000, 1);
        repeat (8) @(posedge linkClk);
        @(negedge clk);
    endtask

    task automatic measure(input logic [31:0] v);
        curVal = v;
        pulse();
        wait_idle();
    endtask

    task automatic test_compare();
        logic [31:0] v [5] = '{32'h32, 32'h64, 32'h96, 32'hc8, 32'hfa};
        logic lo, hi;
        int m0;
        for (int i = 0; i < 5; i++) begin
            measure(v[i]);
            lo = v[i] < 32'h64;
            hi = v[i] > 32'hc8;
            chk({pins.res.belowLimit, pins.res.aboveLimit}, {lo, hi});
            chk({pins.res.passResult, pins.res.failResult}, {!(lo | hi), lo | hi});
            chk({pins.res.customLogicOutOne, pins.res.customLogicOutTwo}, {2{!(lo | hi)}});
            chk({pins.conversionDone, pins.ready, pins.res.grade}, 10'h300);
        end
        // Second trigger lands while the slow engine is still busy
        lag = 8'h3c;
        m0 = mcnt;
        pulse();
        pulse();
        wait_idle();
        chk(mcnt - m0, 1);
        lag = 8'h03;
        // Outside external trigger mode both status pins stay low
        cfg.extTrigMode = 1'b0;
        measure(32'h96);
        chk({pins.conversionDone, pins.ready}, 2'b00);
    endtask

    task automatic test_binning();
        logic exOut;
        cfg.mode = HSR_BINNING;
        cfg.trigFallEdge = 1'b1;
        cfg.customSel[0] = 4'b0001;
        // Let the mode-change flush finish, then restore status pins while idle
        repeat (120) @(negedge clk);
        cfg.extTrigMode = 1'b1;
        repeat (60) @(negedge clk);
        for (int k = 0; k < 9; k++) begin
            exOut = (k == 8 || k == 3);
            measure(k * 32'h64 + 32'h63);
            chk(pins.res.grade, exOut ? 0 : 1 << k);
            chk({pins.res.outOfAllBins, pins.res.customLogicOutOne}, {2{exOut}});
            chk({pins.res.customLogicOutTwo, pins.res.passResult}, 2'b10);
        end
    endtask

    task automatic test_scan(input int n, input int expN, input int dly);
        int k;
        cfg.mode = HSR_SCAN;
        cfg.chanCount = n[6:0];
        cfg.scanDelay = dly[23:0];
        // A trigger during the mode-change flush would be dropped
        repeat (120) @(negedge clk);
        grpQ.delete();
        strbCnt = 0;
        mcnt = 0;
        minGap = 100000;
        pulse();
        k = 0;
        while (strbCnt == 0 && k < 8000) begin
            @(negedge clk);
            k++;
        end
        repeat (4) @(posedge linkClk);
        @(negedge clk);
        chk(grpQ.size(), expN);
        chk(strbCnt, 1);
        chk(minGap > dly, 1);
        foreach (grpQ[i])
            chk({grpQ[i].relayControl, grpQ[i].scanPass, grpQ[i].scanLow, grpQ[i].scanHigh},
                {i < expN - 1, i % 3 == 1, i % 3 == 0, i % 3 == 2});
        chk({pins.res.passResult, pins.conversionDone, pins.ready}, 0);
    endtask

    // Watchdog sized well above the expected run
    initial begin
        #400000;
        err_count++;
        complete_run();
    end

    initial begin
        reset = 1'b1;
        ce = 1'b1;
        trigPin = 1'b0;
        lag = 8'h03;
        curVal = 32'h0;
        cfg = '0;
        cfg.extTrigMode = 1'b1;
        cfg.lowLimit = 32'h64;
        cfg.highLimit = 32'hc8;
        cfg.binEnable = 8'hf7;
        for (int k = 0; k < 8; k++) begin
            cfg.binLow[k] = k * 32'h64;
            cfg.binHigh[k] = k * 32'h64 + 32'h63;
        end
        cfg.customSel = {4'b0110, 4'b1000};
        cfg.customLevel = 2'b01;
        repeat (12) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        repeat (8) @(posedge linkClk);
        @(negedge clk);
        chk(pins, 32'h4);
        test_compare();
        test_binning();
        test_scan(3, 3, 5);
        test_scan(7, 4, 200);
        complete_run();
    end
endmodule // tb_hsr_handler_scan
